//--- hdl/sgc_params.svh
// Constants for the scan gate and command parser block
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

// Register byte offsets
`define SGC_OFF_RES0 12'h000
`define SGC_OFF_RES1 12'h004
`define SGC_OFF_RES2 12'h008
`define SGC_OFF_RES3 12'h00c
`define SGC_OFF_CTRL 12'h010
`define SGC_OFF_STAT 12'h014

// Control and status bit positions
`define SGC_CTRL_CLR 0
`define SGC_ST_CONCL 1
`define SGC_ST_NODEC 2

// Result block and version reply sizes
`define SGC_RES_BYTES 11
`define SGC_VER_LEN 16

// Characters
`define SGC_CH_NOREAD 8'h3f
`define SGC_CH_CR 8'h0d
`define SGC_CH_LF 8'h0a
`define SGC_CH_V 8'h56
`define SGC_CH_H 8'h48
`define SGC_CH_C 8'h43
`define SGC_CH_A 8'h41
`define SGC_CH_S 8'h53
`define SGC_CH_PLUS 8'h2b
`define SGC_CH_MINUS 8'h2d
`define SGC_CH_ONE 8'h31
`define SGC_CH_ZERO 8'h30

// Auto setup status digits
`define SGC_AS_OK 8'h30
`define SGC_AS_INVALID 8'h31
`define SGC_AS_NO_ACT 8'h32
`define SGC_AS_NO_DEACT 8'h33
`define SGC_AS_NO_DEL 8'h34

`endif

//--- hdl/sgc_pkg.sv
// Types for the scan gate and command parser block
`include "sgc_params.svh"
package sgc_pkg;

    // Reply generator modes
    typedef enum logic [3:0] {
        SGC_RPL_IDLE  = 4'b0001,
        SGC_RPL_VER   = 4'b0010,
        SGC_RPL_AUTO  = 4'b0100,
        SGC_RPL_START = 4'b1000
    } sgc_reply_t;

    // Decoder result carrier
    typedef struct packed {
        logic valid;
        logic [7:0] len;
        logic [8*`SGC_RES_BYTES-1:0] data;
    } sgc_dec_t;

    // Received command character carrier
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sgc_byte_t;

    // Whole state of the block
    typedef struct packed {
        logic sw_meta;
        logic sw_sync;
        logic sw_prev;
        logic gate;
        logic got_read;
        logic pend_nr;
        logic concluded;
        logic nodecode;
        logic [7:0] len;
        logic [8*`SGC_RES_BYTES-1:0] data;
        logic auto_act;
        logic [23:0] cmd;
        logic [1:0] cmd_cnt;
        logic cmd_ovf;
        logic cmd_busy;
        logic cmd_src;
        sgc_reply_t reply;
        logic [7:0] code;
        logic [4:0] idx;
        logic reply_src;
        logic [8:0] fifo0;
        logic [8:0] fifo1;
        logic [1:0] fcnt;
        logic [31:0] prdata;
        logic pslverr;
    } sgc_state_t;

endpackage : sgc_pkg

//--- hdl/sgc_top.sv
// Scan gate, decoding result block and online command parser
//
// Added by the designer: the placing of the registers and register access over APB.
`include "sgc_params.svh"
module sgc_top
    import sgc_pkg::*;
#(
    // Reply line of the version query; value is arbitrary
    parameter logic [8*`SGC_VER_LEN-1:0] VERSION_TEXT = "DEV0 V0.0 000000"
) (
    input wire logic sys_clk,
    input wire logic reset,
    // Switching input from the presence sensor
    input wire logic switching_line_one,
    // Decoder result, same clock
    input wire sgc_dec_t dec_in,
    // Command characters from host and service interfaces
    input wire sgc_byte_t host_rx,
    output logic host_rx_ready,
    input wire sgc_byte_t svc_rx,
    output logic svc_rx_ready,
    // Reply characters
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_svc,
    // Reading gate state
    output logic scan_gate,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Fold lower case letters onto upper case
    function automatic logic [7:0] sgc_upper(input logic [7:0] c);
        if (c >= 8'h61 && c <= 8'h7a) begin
            return c - 8'h20;
        end
        return c;
    endfunction : sgc_upper

    // Mapped register offsets
    function automatic logic sgc_mapped(input logic [11:0] a);
        case (a)
            `SGC_OFF_RES0, `SGC_OFF_RES1, `SGC_OFF_RES2, `SGC_OFF_RES3,
            `SGC_OFF_CTRL, `SGC_OFF_STAT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : sgc_mapped

    // Reply character at a position; bit 8 marks the last one
    function automatic logic [8:0] sgc_reply_char(
        input sgc_reply_t kind,
        input logic [4:0] i,
        input logic [7:0] code
    );
        logic [8:0] r;
        r = {1'b1, `SGC_CH_S};
        case (kind)
            SGC_RPL_VER: begin
                if (i < 5'(`SGC_VER_LEN)) begin
                    r = {1'b0, VERSION_TEXT[8*(`SGC_VER_LEN-1-i) +: 8]};
                end else if (i == 5'(`SGC_VER_LEN)) begin
                    r = {1'b0, `SGC_CH_CR};
                end else begin
                    r = {1'b1, `SGC_CH_LF};
                end
            end
            SGC_RPL_AUTO: begin
                case (i)
                    5'h00: r = {1'b0, `SGC_CH_C};
                    5'h01: r = {1'b0, `SGC_CH_S};
                    5'h02: r = {1'b0, code};
                    5'h03: r = {1'b0, `SGC_CH_CR};
                    default: r = {1'b1, `SGC_CH_LF};
                endcase
            end
            SGC_RPL_START: r = {1'b1, `SGC_CH_S};
            default: r = {1'b1, `SGC_CH_S};
        endcase
        return r;
    endfunction : sgc_reply_char

    ////////////////////////////////////////////////////////////////////////////
    // State and decoded conditions

    sgc_state_t state_r;
    sgc_state_t state_nxt;
    sgc_state_t reset_state;

    logic sw_rise;
    logic sw_fall;
    logic reply_idle;
    logic host_take;
    logic svc_take;
    logic rx_take;
    logic [7:0] rx_char;
    logic rx_src;
    logic apb_setup;
    logic apb_wr_ctrl;
    logic [127:0] res_blk;
    logic [7:0] res_status;
    logic [7:0] cmd0;
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic fifo_push;
    logic fifo_pop;
    logic [9:0] push_word;

    // Power-on value of every state bit
    always_comb begin
        reset_state = '0;
        reset_state.reply = SGC_RPL_IDLE;
    end

    // Edges of the synchronised switching line
    assign sw_rise = state_r.sw_sync & ~state_r.sw_prev;
    assign sw_fall = ~state_r.sw_sync & state_r.sw_prev;

    // Command characters: one source owns a command until its delimiter
    assign reply_idle = (state_r.reply == SGC_RPL_IDLE);
    assign host_rx_ready = reply_idle & (~state_r.cmd_busy | ~state_r.cmd_src);
    assign svc_rx_ready = reply_idle &
        (state_r.cmd_busy ? state_r.cmd_src : ~host_rx.valid);
    assign host_take = host_rx.valid & host_rx_ready;
    assign svc_take = svc_rx.valid & svc_rx_ready;
    assign rx_take = host_take | svc_take;
    assign rx_char = host_take ? host_rx.data : svc_rx.data;
    assign rx_src = ~host_take;

    // Stored command, code letters folded to upper case, parameter kept as received
    assign cmd0 = sgc_upper(state_r.cmd[7:0]);
    assign cmd1 = sgc_upper(state_r.cmd[15:8]);
    assign cmd2 = state_r.cmd[23:16];

    // Decoding result block as bytes 0 to 12
    always_comb begin
        res_status = 8'h00;
        res_status[`SGC_ST_CONCL] = state_r.concluded;
        res_status[`SGC_ST_NODEC] = state_r.nodecode;
        res_blk = '0;
        res_blk[8*(`SGC_RES_BYTES+2)-1:0] = {state_r.data, state_r.len, res_status};
    end

    // APB decode
    assign apb_setup = psel & ~penable;
    assign apb_wr_ctrl = psel & penable & pwrite & (paddr == `SGC_OFF_CTRL);

    // Reply buffer handshakes
    assign push_word = {state_r.reply_src,
        sgc_reply_char(state_r.reply, state_r.idx, state_r.code)};
    assign fifo_push = ~reply_idle & (state_r.fcnt != 2'd2);
    assign fifo_pop = tx_ready & (state_r.fcnt != 2'd0);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic soft_rst;
        logic [8:0] ch;
        soft_rst = 1'b0;
        ch = '0;
        state_nxt = state_r;

        // Two flip-flop synchroniser and edge history
        state_nxt.sw_meta = switching_line_one;
        state_nxt.sw_sync = state_r.sw_meta;
        state_nxt.sw_prev = state_r.sw_sync;

        // Reading gate
        if (sw_rise) begin
            state_nxt.gate = 1'b1;
            state_nxt.got_read = 1'b0;
        end
        if (sw_fall) begin
            state_nxt.gate = 1'b0;
            if (!state_r.got_read) begin
                state_nxt.pend_nr = 1'b1;
            end
        end

        // Software clear of the result; hardware sets below win
        if (apb_wr_ctrl && pwdata[`SGC_CTRL_CLR]) begin
            state_nxt.concluded = 1'b0;
            state_nxt.nodecode = 1'b0;
        end

        // Good read while the gate is open, first result only
        if (state_r.gate && dec_in.valid && !state_r.got_read) begin
            state_nxt.got_read = 1'b1;
            state_nxt.concluded = 1'b1;
            state_nxt.nodecode = 1'b0;
            state_nxt.len = (dec_in.len > 8'(`SGC_RES_BYTES)) ?
                8'(`SGC_RES_BYTES) : dec_in.len;
            state_nxt.data = dec_in.data;
        end

        // No-read reported one cycle after the gate closed
        if (state_r.pend_nr) begin
            state_nxt.pend_nr = 1'b0;
            state_nxt.concluded = 1'b1;
            state_nxt.nodecode = 1'b1;
            state_nxt.len = 8'h01;
            state_nxt.data = '0;
            state_nxt.data[7:0] = `SGC_CH_NOREAD;
        end

        // Command assembly and execution
        if (rx_take) begin
            if (rx_char == `SGC_CH_CR) begin
                state_nxt.cmd_busy = 1'b0;
                state_nxt.cmd_cnt = 2'd0;
                state_nxt.cmd_ovf = 1'b0;
                state_nxt.cmd = '0;
                if (!state_r.cmd_ovf && state_r.cmd_cnt == 2'd1 && cmd0 == `SGC_CH_V) begin
                    state_nxt.reply = SGC_RPL_VER;
                    state_nxt.idx = 5'd0;
                    state_nxt.reply_src = rx_src;
                end else if (!state_r.cmd_ovf && state_r.cmd_cnt == 2'd1 &&
                        cmd0 == `SGC_CH_H) begin
                    soft_rst = 1'b1;
                end else if (!state_r.cmd_ovf && state_r.cmd_cnt == 2'd3 &&
                        cmd0 == `SGC_CH_C && cmd1 == `SGC_CH_A) begin
                    state_nxt.reply = SGC_RPL_AUTO;
                    state_nxt.idx = 5'd0;
                    state_nxt.reply_src = rx_src;
                    // Parameter directly after the code
                    case (cmd2)
                        `SGC_CH_PLUS: begin
                            if (state_r.gate) begin
                                state_nxt.code = `SGC_AS_NO_ACT;
                            end else begin
                                state_nxt.auto_act = 1'b1;
                                state_nxt.code = `SGC_AS_OK;
                            end
                        end
                        `SGC_CH_MINUS: begin
                            if (state_r.gate) begin
                                state_nxt.code = `SGC_AS_NO_DEACT;
                            end else begin
                                state_nxt.auto_act = 1'b0;
                                state_nxt.code = `SGC_AS_OK;
                            end
                        end
                        `SGC_CH_ONE: begin
                            // A no-read landing this cycle must not be lost
                            if (!state_r.concluded || state_r.gate || state_r.pend_nr) begin
                                state_nxt.code = `SGC_AS_NO_DEL;
                            end else begin
                                state_nxt.concluded = 1'b0;
                                state_nxt.nodecode = 1'b0;
                                state_nxt.code = `SGC_AS_OK;
                            end
                        end
                        default: state_nxt.code = `SGC_AS_INVALID;
                    endcase
                end
                // Anything else falls through silently
            end else begin
                state_nxt.cmd_busy = 1'b1;
                state_nxt.cmd_src = rx_src;
                if (state_r.cmd_cnt == 2'd3) begin
                    state_nxt.cmd_ovf = 1'b1;
                end else begin
                    state_nxt.cmd[8*state_r.cmd_cnt +: 8] = rx_char;
                    state_nxt.cmd_cnt = state_r.cmd_cnt + 2'd1;
                end
            end
        end

        // Reply generator feeds the buffer one character per cycle
        if (fifo_push) begin
            if (push_word[8]) begin
                state_nxt.reply = SGC_RPL_IDLE;
                state_nxt.idx = 5'd0;
            end else begin
                state_nxt.idx = state_r.idx + 5'd1;
            end
        end

        // Two-entry reply buffer
        ch = {push_word[9], push_word[7:0]};
        case ({fifo_push, fifo_pop})
            2'b10: begin
                if (state_r.fcnt == 2'd0) begin
                    state_nxt.fifo0 = ch;
                end else begin
                    state_nxt.fifo1 = ch;
                end
                state_nxt.fcnt = state_r.fcnt + 2'd1;
            end
            2'b01: begin
                state_nxt.fifo0 = state_r.fifo1;
                state_nxt.fcnt = state_r.fcnt - 2'd1;
            end
            2'b11: begin
                state_nxt.fifo0 = ch;
            end
            default: begin
            end
        endcase

        // APB read data and error captured in the setup cycle
        if (apb_setup) begin
            state_nxt.pslverr = ~sgc_mapped(paddr);
            case (paddr)
                `SGC_OFF_RES0: state_nxt.prdata = res_blk[31:0];
                `SGC_OFF_RES1: state_nxt.prdata = res_blk[63:32];
                `SGC_OFF_RES2: state_nxt.prdata = res_blk[95:64];
                `SGC_OFF_RES3: state_nxt.prdata = res_blk[127:96];
                `SGC_OFF_STAT: state_nxt.prdata = {28'h0000000, ~reply_idle,
                    state_r.cmd_busy, state_r.auto_act, state_r.gate};
                default: state_nxt.prdata = 32'h00000000;
            endcase
        end

        // Software reset: power-on state, then the start character
        if (soft_rst) begin
            state_nxt = reset_state;
            state_nxt.reply = SGC_RPL_START;
            state_nxt.reply_src = rx_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= reset_state;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Reply stream
    assign tx_valid = (state_r.fcnt != 2'd0);
    assign tx_data = state_r.fifo0[7:0];
    assign tx_svc = state_r.fifo0[8];

    // Gate and bus answers
    assign scan_gate = state_r.gate;
    assign prdata = state_r.prdata;
    assign pslverr = state_r.pslverr & psel & penable;
    assign pready = psel & penable;

endmodule : sgc_top

//--- tb/sgc_host_model.sv
// Host and service computer model: sends commands, takes replies
`include "sgc_params.svh"
module sgc_host_model
    import sgc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic host_rx_ready,
    input wire logic svc_rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_svc,
    output sgc_byte_t host_rx,
    output sgc_byte_t svc_rx,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] rx_q[$];
    initial begin
        host_rx = '0;
        svc_rx = '0;
        tx_ready = 1'b0;
    end
    // Receiver stalls at random
    always @(posedge sys_clk) tx_ready <= ($urandom_range(3) != 0);
    // Collect replies as source flag and character
    always @(posedge sys_clk) if (tx_valid && tx_ready) rx_q.push_back({tx_svc, tx_data});
    // Code and parameters back to back, then carriage return
    task automatic send(input string s, input logic svc);
        sgc_byte_t b;
        @(posedge sys_clk);
        for (int i = 0; i <= s.len(); i++) begin
            b.valid = 1'b1;
            b.data = (i == s.len()) ? `SGC_CH_CR : 8'(s[i]);
            if (svc) svc_rx <= b;
            else host_rx <= b;
            // Held until the edge that sees ready high
            do @(posedge sys_clk); while ((svc ? svc_rx_ready : host_rx_ready) !== 1'b1);
        end
        // Released line shows the inverse of the last character
        b = {1'b0, ~b.data};
        if (svc) svc_rx <= b;
        else host_rx <= b;
    endtask : send
endmodule : sgc_host_model

//--- tb/sgc_top_sva.sv
// Port checker of the scan gate and command parser
`include "sgc_params.svh"
module sgc_top_sva
    import sgc_pkg::*;
#(
    parameter logic [8*`SGC_VER_LEN-1:0] VERSION_TEXT = "DEV0 V0.0 000000"
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic switching_line_one,
    input wire sgc_dec_t dec_in,
    input wire sgc_byte_t host_rx,
    input wire logic host_rx_ready,
    input wire sgc_byte_t svc_rx,
    input wire logic svc_rx_ready,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_svc,
    input wire logic scan_gate,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire logic h_take = host_rx.valid && host_rx_ready;
    wire logic s_take = svc_rx.valid && svc_rx_ready;
    ////////////////////////////////////////////////////////////////
    // Lone command letter, any case, ended by carriage return
    sequence s_cmd1(t, d, c);
        !t ##1 t && ((d | 8'h20) == c) ##1 t && d == `SGC_CH_CR;
    endsequence
    // Upper case auto setup code with one parameter
    sequence s_ca;
        !h_take ##1 h_take && host_rx.data == `SGC_CH_C ##1 h_take && host_rx.data == `SGC_CH_A
            ##1 h_take ##1 h_take && host_rx.data == `SGC_CH_CR;
    endsequence
    sequence s_apb;
        psel && !penable ##1 psel && penable;
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_GATE_OPEN: assert property (switching_line_one [*4] |=> scan_gate)
        else $error("gate not opened");
    AST_GATE_CLOSE: assert property ((!switching_line_one) [*4] |=> !scan_gate)
        else $error("gate not closed");
    AST_APB_ACCESS: assert property (s_apb |-> pready ##1 $stable(prdata))
        else $error("access phase wrong");
    AST_APB_ERROR: assert property (psel && penable |-> pslverr == (paddr > `SGC_OFF_STAT))
        else $error("error response wrong");
    AST_ERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_svc, tx_data}))
        else $error("reply char lost");
    AST_VER_HOST: assert property (s_cmd1(h_take, host_rx.data, 8'h76) |->
            ##2 tx_valid && !tx_svc && tx_data == VERSION_TEXT[8*`SGC_VER_LEN-1-:8])
        else $error("version reply wrong");
    AST_VER_SVC: assert property (s_cmd1(s_take, svc_rx.data, 8'h76) |->
            ##2 tx_valid && tx_svc && tx_data == VERSION_TEXT[8*`SGC_VER_LEN-1-:8])
        else $error("service reply wrong");
    AST_CS_REPLY: assert property (s_ca |-> ##2 tx_valid && tx_data == `SGC_CH_C)
        else $error("auto setup reply wrong");
    AST_START_CHAR: assert property (s_cmd1(h_take, host_rx.data, 8'h68) |->
            ##[1:6] tx_valid && tx_data == `SGC_CH_S)
        else $error("start char missing");
    AST_UNK_SILENT: assert property (!h_take ##1 h_take && host_rx.data == 8'h51
            ##1 h_take && host_rx.data == `SGC_CH_CR |=> !tx_valid [*6])
        else $error("unknown code replied");
endmodule : sgc_top_sva
bind sgc_top sgc_top_sva #(.VERSION_TEXT(VERSION_TEXT)) i_sva (
    .sys_clk(sys_clk), .reset(reset), .switching_line_one(switching_line_one),
    .dec_in(dec_in), .host_rx(host_rx), .host_rx_ready(host_rx_ready), .svc_rx(svc_rx),
    .svc_rx_ready(svc_rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_svc(tx_svc), .scan_gate(scan_gate), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

//--- tb/test_scan_gate_and_command_parser.sv
// Self-checking bench of the scan gate and command parser
`include "sgc_params.svh"
module test_scan_gate_and_command_parser
    import sgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [127:0] VER = "TST1 V0.1 010101"; // Arbitrary reply text
    localparam string CRLF = "\015\012";
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic switching_line_one = 1'b0;
    sgc_dec_t dec_in = '0;
    sgc_byte_t host_rx, svc_rx;
    logic host_rx_ready, svc_rx_ready, tx_valid, tx_ready, tx_svc, scan_gate, pready, pslverr, e;
    logic [7:0] tx_data, len;
    logic [11:0] paddr = '0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [87:0] dat;
    int err_total = 0, check_count = 0, cyc = 0;
    string bad[5] = '{"Q", "VV", "CA +", "h1", "CAB+"};

    sgc_top #(.VERSION_TEXT(VER)) i_dut (.sys_clk(sys_clk), .reset(reset),
        .switching_line_one(switching_line_one), .dec_in(dec_in), .host_rx(host_rx),
        .host_rx_ready(host_rx_ready), .svc_rx(svc_rx), .svc_rx_ready(svc_rx_ready),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_svc(tx_svc),
        .scan_gate(scan_gate), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sgc_host_model i_host (.sys_clk(sys_clk), .host_rx_ready(host_rx_ready),
        .svc_rx_ready(svc_rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_svc(tx_svc),
        .host_rx(host_rx), .svc_rx(svc_rx), .tx_ready(tx_ready));

    // Clock and hang guard
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk
    // One bus transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Read data and error taken at the edge that sees pready
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] k, string m);
        apb(1'b0, a, 32'h0);
        chk(q & k, x, m);
    endtask : rd
    task automatic gate(input logic v);
        @(posedge sys_clk);
        switching_line_one <= v;
        do @(negedge sys_clk); while (scan_gate !== v);
        rd(`SGC_OFF_STAT, {31'h0, v}, 32'h1, "gate state");
    endtask : gate
    task automatic pulse(input logic [7:0] l, input logic [87:0] d);
        @(posedge sys_clk);
        dec_in <= '{valid: 1'b1, len: l, data: d};
        @(posedge sys_clk);
        dec_in.valid <= 1'b0;
    endtask : pulse
    // Expected result word after a good read
    function automatic logic [31:0] res_w(input int w, input logic [7:0] l, logic [87:0] d);
        logic [127:0] b;
        b = {24'h0, d, l, 8'h02};
        return b[32*w+:32];
    endfunction : res_w
    task automatic cmd(input string c, input logic svc, input string r);
        i_host.send(c, svc);
        while (i_host.rx_q.size() < r.len()) @(negedge sys_clk);
        repeat (8) @(negedge sys_clk);
        chk(i_host.rx_q.size(), r.len(), {"reply count ", c});
        for (int i = 0; i < i_host.rx_q.size(); i++) chk(i_host.rx_q[i], {svc, r[i]}, c);
        i_host.rx_q.delete();
    endtask : cmd
    ////////////////////////////////////////////////////////////////
    initial begin
        q = $urandom(62674);
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        for (int a = 0; a < 6; a++) rd(12'(4 * a), 32'h0, '1, "reset value");
        apb(1'b1, `SGC_OFF_RES0, 32'hffffffff);
        rd(`SGC_OFF_RES0, 32'h0, '1, "read-only write");
        apb(1'b0, 12'h018, 32'h0);
        chk({q[30:0], e}, 32'h1, "unmapped");
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            len = (k == 0) ? 8'd11 : (k == 1) ? 8'd1 : 8'($urandom_range(1, 11));
            dat = 88'({$urandom, $urandom, $urandom});
            gate(1'b1);
            pulse(len, dat);
            pulse(8'd3, ~dat);
            for (int w = 0; w < 4; w++) rd(12'(4 * w), res_w(w, len, dat), '1, "read");
            gate(1'b0);
            rd(`SGC_OFF_RES0, res_w(0, len, dat), '1, "kept after close");
            apb(1'b1, `SGC_OFF_CTRL, 32'h1);
            rd(`SGC_OFF_RES0, 32'h0, 32'hff, "flags cleared");
        end
        gate(1'b1);
        gate(1'b0);
        rd(`SGC_OFF_RES0, 32'h3f0106, 32'hffffff, "no read");
        $display("test gate done");
        cmd("CA1", 1'b0, {"CS0", CRLF});
        rd(`SGC_OFF_RES0, 32'h0, 32'hff, "result deleted");
        cmd("CA1", 1'b1, {"CS4", CRLF});
        cmd("CA+", 1'b0, {"CS0", CRLF});
        cmd("ca-", 1'b1, {"CS0", CRLF});
        cmd("CA7", 1'b0, {"CS1", CRLF});
        gate(1'b1);
        cmd("cA+", 1'b0, {"CS2", CRLF});
        cmd("Ca-", 1'b1, {"CS3", CRLF});
        gate(1'b0);
        cmd("V", 1'b0, {string'(VER), CRLF});
        cmd("v", 1'b1, {string'(VER), CRLF});
        cmd("CA+", 1'b0, {"CS0", CRLF});
        foreach (bad[i]) cmd(bad[i], i[0], "");
        rd(`SGC_OFF_STAT, 32'h2, 32'h2, "state kept");
        cmd("H", 1'b0, "S");
        rd(`SGC_OFF_STAT, 32'h0, '1, "state after reset");
        rd(`SGC_OFF_RES0, 32'h0, '1, "result after reset");
        $display("test commands done");
        results();
    end
endmodule : test_scan_gate_and_command_parser
